/* File: hdl/pps_pkg.sv */
// pps_pkg: constants, states and timing counts for the power-off / reset sequencer
// assumes a single 25 MHz system clock
package pps_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned CNT_W = 16;
  // shortest accepted power key low pulse, in microseconds
  localparam int unsigned KEY_MIN_US = 1000;
  localparam logic [CNT_W-1:0] KEY_MIN_CYC = CNT_W'((KEY_MIN_US * (CLK_HZ / 1000000)));
  // hard reset low time compared on release from off, in microseconds; shorter holds reboot too
  localparam int unsigned HRST_REBOOT_US = 2000;
  localparam logic [CNT_W-1:0] HRST_REBOOT_CYC = CNT_W'((HRST_REBOOT_US * (CLK_HZ / 1000000)));
  // length of the baseband reset pulse on the reboot path, in cycles
  localparam logic [3:0] BB_RST_CYC = 4'h8;
  // number of sync stages for pin inputs
  localparam int unsigned SYNC_N = 3;
  // sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_OFF     = 7'h01,
    ST_BOOT    = 7'h02,
    ST_ON      = 7'h04,
    ST_SAVE    = 7'h08,
    ST_DETACH  = 7'h10,
    ST_HALT    = 7'h20,
    ST_SWRST   = 7'h40
  } pps_state_t;
  // what the orderly routine ends in
  typedef enum logic [1:0] {
    END_OFF    = 2'h1,
    END_REBOOT = 2'h2
  } pps_end_t;
endpackage : pps_pkg

/* File: hdl/pps_sync.sv */
// pps_sync: three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk_sys; output is the agreed level
`timescale 1ns/1ns
`default_nettype none
module pps_sync
  import pps_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pin,
  output logic level
);
  logic [SYNC_N-1:0] sh_r;
  logic [SYNC_N-1:0] sh_nxt;
  logic level_r;
  logic level_nxt;

  // shift in, accept a change only when stages two and three agree
  always_comb begin
    sh_nxt = {sh_r[SYNC_N-2:0], pin};
    level_nxt = (sh_r[1] == sh_r[2]) ? sh_r[2] : level_r;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sh_r <= {SYNC_N{RST_VAL}};
      level_r <= RST_VAL;
    end else begin
      sh_r <= sh_nxt;
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule : pps_sync
`default_nettype wire

/* File: hdl/pps_seq.sv */
// pps_seq: power-off and reset sequencer of a cellular module
// assumes pins are idle high (internal pull-ups); commands arrive as one-cycle pulses
// from the command decoder on clk_sys; save/detach/boot helpers answer with done pulses
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// R1 - poweroff command starts switch-off: save settings, detach, then shut down
// R2 - ok answer is given while switch-off routine is still running
// R3 - power key low then released starts orderly switch-off
// R4 - at end, pins tri-stated and regulators off, interface supply low; backup_supply is kept on
// R5 - stay off until power key pulse or hard reset release
// R6 - host keeps main supply until interface supply goes low
// R7 - main supply loss gives abrupt shutdown, no save, no detach
// R8 - hard reset low while running shuts down immediately, no save
// R9 - host uses hard reset only as a fallback
// R10 - function reset command saves, detaches, then resets baseband
// R11 - hard reset held long reboots abruptly, no save, no detach
// R12 - enabled temperature supervisor shuts down on over or under limit
// R13 - hard reset input reads high when undriven
// R14 - from off, power key pulse or hard reset release starts switch-on
// R15 - power key pulses shorter than minimum are ignored
module pps_seq
  import pps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic power_key_n,
  input wire logic hard_reset_n,
  input wire logic hard_reset_n_oe_n,
  input wire logic main_supply_ok,
  input wire logic poweroff_command,
  input wire logic function_reset_command,
  input wire logic temperature_supervisor_command,
  input wire logic temp_sup_en,
  input wire logic temp_out_of_range,
  input wire logic save_done,
  input wire logic detach_done,
  input wire logic boot_done,
  output logic cmd_ok,
  output logic save_req,
  output logic detach_req,
  output logic bb_reset_n,
  output logic int_supply_en,
  output logic pins_oe_n,
  output logic backup_supply,
  output logic powered_on
);
  logic key_lvl;
  logic hrst_pin;
  logic hrst_lvl;
  pps_state_t st_r, st_nxt;
  pps_end_t end_r, end_nxt;
  logic [CNT_W-1:0] key_cnt_r, key_cnt_nxt;
  logic [CNT_W-1:0] hrst_cnt_r, hrst_cnt_nxt;
  logic [3:0] bb_cnt_r, bb_cnt_nxt;
  logic key_prev_r, key_prev_nxt;
  logic hrst_prev_r, hrst_prev_nxt;
  logic tsup_en_r, tsup_en_nxt;
  logic bkup_r, bkup_nxt;
  logic ok_r, ok_nxt;
  logic save_r, save_nxt;
  logic det_r, det_nxt;
  logic bbrst_r, bbrst_nxt;
  logic vint_r, vint_nxt;
  logic oe_n_r, oe_n_nxt;
  logic key_pulse;
  logic hrst_rise;
  logic hrst_fall;

  // undriven hard reset reads high through the pull-up
  assign hrst_pin = hard_reset_n_oe_n ? 1'b1 : hard_reset_n; // R13

  pps_sync #(.RST_VAL(1'b1)) u_key (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(power_key_n),
    .level(key_lvl)
  );

  pps_sync #(.RST_VAL(1'b1)) u_hrst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin(hrst_pin),
    .level(hrst_lvl)
  );

  // hard reset edges and a valid-length key pulse
  assign key_pulse = key_lvl && !key_prev_r && (key_cnt_r >= KEY_MIN_CYC); // R3 R15
  assign hrst_rise = hrst_lvl && !hrst_prev_r;
  assign hrst_fall = !hrst_lvl && hrst_prev_r;

  // pulse-length counters and supervisor enable
  always_comb begin
    key_prev_nxt = key_lvl;
    hrst_prev_nxt = hrst_lvl;
    key_cnt_nxt = key_cnt_r;
    if (!key_lvl) begin
      if (key_cnt_r != {CNT_W{1'b1}}) begin
        key_cnt_nxt = key_cnt_r + CNT_W'(1); // R15
      end
    end else if (key_prev_r) begin
      key_cnt_nxt = '0;
    end
    hrst_cnt_nxt = hrst_cnt_r;
    if (!hrst_lvl) begin
      if (hrst_cnt_r != {CNT_W{1'b1}}) begin
        hrst_cnt_nxt = hrst_cnt_r + CNT_W'(1);
      end
    end else begin
      hrst_cnt_nxt = '0;
    end
    // backup supply stays on whatever the sequencer does
    bkup_nxt = 1'b1; // R4 R7
    tsup_en_nxt = tsup_en_r;
    if (temperature_supervisor_command) begin
      tsup_en_nxt = temp_sup_en; // R12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      key_prev_r <= 1'b1;
      hrst_prev_r <= 1'b1;
      key_cnt_r <= '0;
      hrst_cnt_r <= '0;
      tsup_en_r <= 1'b0;
      bkup_r <= 1'b1;
    end else begin
      key_prev_r <= key_prev_nxt;
      hrst_prev_r <= hrst_prev_nxt;
      key_cnt_r <= key_cnt_nxt;
      hrst_cnt_r <= hrst_cnt_nxt;
      tsup_en_r <= tsup_en_nxt;
      bkup_r <= bkup_nxt;
    end
  end

  // sequencer next state and outputs
  always_comb begin
    st_nxt = st_r;
    end_nxt = end_r;
    bb_cnt_nxt = bb_cnt_r;
    ok_nxt = 1'b0;
    save_nxt = 1'b0;
    det_nxt = 1'b0;
    bbrst_nxt = bbrst_r;
    vint_nxt = vint_r;
    oe_n_nxt = oe_n_r;
    if (!main_supply_ok) begin
      st_nxt = ST_OFF; // R7
      vint_nxt = 1'b0;
      oe_n_nxt = 1'b1;
      bbrst_nxt = 1'b0;
    end else if (st_r != ST_OFF && !hrst_lvl) begin
      // immediate shutdown, held low for any length becomes reboot on release
      st_nxt = ST_OFF; // R8
      vint_nxt = 1'b0;
      oe_n_nxt = 1'b1;
      bbrst_nxt = 1'b0;
    end else begin
      case (st_r)
        ST_OFF: begin
          bbrst_nxt = 1'b0;
          // R5 R14: key pulse or hard reset release switches on; long hold reboots
          if (key_pulse || (hrst_rise && hrst_cnt_r >= HRST_REBOOT_CYC) || hrst_rise) begin
            st_nxt = ST_BOOT; // R11 R14
            vint_nxt = 1'b1;
          end
        end
        ST_BOOT: begin
          bbrst_nxt = 1'b1;
          if (boot_done) begin
            st_nxt = ST_ON;
            oe_n_nxt = 1'b0;
          end
        end
        ST_ON: begin
          if (poweroff_command || key_pulse) begin
            st_nxt = ST_SAVE; // R1 R3
            end_nxt = END_OFF;
            save_nxt = 1'b1;
            ok_nxt = poweroff_command; // R2
          end else if (function_reset_command) begin
            st_nxt = ST_SAVE; // R10
            end_nxt = END_REBOOT;
            save_nxt = 1'b1;
            ok_nxt = 1'b1;
          end else if (tsup_en_r && temp_out_of_range) begin
            st_nxt = ST_HALT; // R12
          end
        end
        ST_SAVE: begin
          if (save_done) begin
            st_nxt = ST_DETACH; // R1
            det_nxt = 1'b1;
          end
        end
        ST_DETACH: begin
          if (detach_done) begin
            if (end_r == END_REBOOT) begin
              st_nxt = ST_SWRST; // R10
              bb_cnt_nxt = BB_RST_CYC;
              bbrst_nxt = 1'b0;
            end else begin
              st_nxt = ST_HALT;
            end
          end
        end
        ST_HALT: begin
          st_nxt = ST_OFF; // R4
          vint_nxt = 1'b0;
          oe_n_nxt = 1'b1;
          bbrst_nxt = 1'b0;
        end
        ST_SWRST: begin
          bb_cnt_nxt = bb_cnt_r - 4'h1;
          if (bb_cnt_r == 4'h1) begin
            st_nxt = ST_BOOT;
            bbrst_nxt = 1'b1;
          end
        end
        default: begin
          st_nxt = ST_OFF;
          vint_nxt = 1'b0;
          oe_n_nxt = 1'b1;
          bbrst_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_r <= ST_OFF;
      end_r <= END_OFF;
      bb_cnt_r <= 4'h0;
      ok_r <= 1'b0;
      save_r <= 1'b0;
      det_r <= 1'b0;
      bbrst_r <= 1'b0;
      vint_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      end_r <= end_nxt;
      bb_cnt_r <= bb_cnt_nxt;
      ok_r <= ok_nxt;
      save_r <= save_nxt;
      det_r <= det_nxt;
      bbrst_r <= bbrst_nxt;
      vint_r <= vint_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  assign cmd_ok = ok_r;
  assign save_req = save_r;
  assign detach_req = det_r;
  assign bb_reset_n = bbrst_r;
  assign int_supply_en = vint_r; // R4 R6
  assign pins_oe_n = oe_n_r;
  assign backup_supply = bkup_r; // R4
  assign powered_on = vint_r;
endmodule : pps_seq
`default_nettype wire

/* File: bench/pps_monitor.sv */
// pps_monitor: port assertions for the power-off and reset sequencer
// assumes pins idle high and helpers answer only after a request
`timescale 1ns/1ns
`default_nettype none
module pps_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic hard_reset_n,
  input wire logic hard_reset_n_oe_n,
  input wire logic main_supply_ok,
  input wire logic poweroff_command,
  input wire logic function_reset_command,
  input wire logic save_done,
  input wire logic detach_done,
  input wire logic cmd_ok,
  input wire logic save_req,
  input wire logic detach_req,
  input wire logic bb_reset_n,
  input wire logic int_supply_en,
  input wire logic pins_oe_n
);
  logic rb_r;
  logic rb_nxt;
  logic hr_eff;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // pin level with the pull-up when undriven
  assign hr_eff = hard_reset_n_oe_n | hard_reset_n;
  // remembers whether the running routine ends in a reboot
  always_comb begin
    rb_nxt = rb_r;
    if (function_reset_command) rb_nxt = 1'b1;
    else if (poweroff_command || (save_req && !cmd_ok)) rb_nxt = 1'b0;
  end
  always_ff @(posedge clk_sys) begin
    rb_r <= nrst ? rb_nxt : 1'b0;
  end
  sequence s_off;
    !int_supply_en && pins_oe_n && !bb_reset_n;
  endsequence
  sequence s_bbrst;
    !bb_reset_n [*8];
  endsequence
  ok_cause_a: assert property (
    cmd_ok |-> save_req && $past(poweroff_command || function_reset_command))
    else $error("ok without command");
  off_refuse_a: assert property (
    !int_supply_en && poweroff_command |=> !cmd_ok && !save_req)
    else $error("command taken while off");
  detach_next_a: assert property (
    save_done && main_supply_ok |=> detach_req)
    else $error("no detach after save");
  halt_off_a: assert property (
    detach_done && !rb_r |=> ##1 s_off)
    else $error("no switch-off after detach");
  reboot_rst_a: assert property (
    detach_done && rb_r |-> ##[1:3] s_bbrst)
    else $error("no baseband reset");
  supply_loss_a: assert property (
    !main_supply_ok && int_supply_en |=> s_off and !save_req)
    else $error("no abrupt shutdown");
  hard_off_a: assert property (
    $fell(hr_eff) && int_supply_en |-> ##[1:6] !int_supply_en)
    else $error("hard reset ignored");
  boot_order_a: assert property (
    $rose(int_supply_en) |-> pins_oe_n ##1 bb_reset_n)
    else $error("bad switch-on order");
endmodule : pps_monitor
bind pps_seq pps_monitor u_mon (.*);
`default_nettype wire

/* File: bench/pps_helper_model.sv */
// pps_helper_model: save, detach and boot helpers behind the sequencer
// assumes one-cycle requests; save and detach answers come after a random wait, boot after a fixed 3 cycles
`timescale 1ns/1ns
`default_nettype none
module pps_helper_model (
  input wire logic clk_sys,
  input wire logic save_req,
  input wire logic detach_req,
  input wire logic bb_reset_n,
  output logic save_done,
  output logic detach_done,
  output logic boot_done
);
  int sd = 0;
  int dd = 0;
  int bd = 0;
  logic bb_q = 1'b0;
  // count down from each request, done lasts one cycle
  always @(posedge clk_sys) begin
    bb_q <= bb_reset_n;
    sd <= save_req ? 2 + $urandom % 6 : (sd > 0 ? sd - 1 : 0);
    dd <= detach_req ? 2 + $urandom % 6 : (dd > 0 ? dd - 1 : 0);
    bd <= (bb_reset_n && !bb_q) ? 3 : (bd > 0 ? bd - 1 : 0);
  end
  assign save_done = sd == 1;
  assign detach_done = dd == 1;
  assign boot_done = bd == 1;
endmodule : pps_helper_model
`default_nettype wire

/* File: bench/pps_seq_test.sv */
// pps_seq_test: self-checking bench for the sequencer
// assumes the helper model answers save, detach and boot requests
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %0h seen %0h", n, e, g); end end
module pps_seq_test
  import pps_pkg::*;
;
  logic clk_sys, nrst, power_key_n, hard_reset_n, hard_reset_n_oe_n, main_supply_ok;
  logic poweroff_command, function_reset_command, temperature_supervisor_command;
  logic temp_sup_en, temp_out_of_range, save_done, detach_done, boot_done, cmd_ok;
  logic save_req, detach_req, bb_reset_n, int_supply_en, pins_oe_n, backup_supply, powered_on;
  int mismatches = 0;
  int checks_done = 0;
  int exp_on = 0;
  pps_seq u_dut (.*);
  pps_helper_model u_help (.*);
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask
  function automatic logic pick(int k);
    case (k)
      0: return int_supply_en;
      1: return pins_oe_n;
      2: return bb_reset_n;
      3: return save_req;
      default: return detach_req;
    endcase
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // wait for a port to reach a level, bounded, then compare it
  task automatic wt(int k, logic v);
    int i;
    for (i = 0; i < 3000 && pick(k) !== v; i++) cyc(1);
    `CHK("wait", v, pick(k))
    if (i == 3000) print_verdict();
  endtask
  // model of the supply state compared with the outputs
  task automatic cmp();
    `CHK("supply", exp_on[0], int_supply_en)
    `CHK("powered", exp_on[0], powered_on)
    `CHK("backup", 1'b1, backup_supply)
  endtask
  // hard reset pulse: shuts down if running, then switches on
  task automatic turn_on();
    hard_reset_n_oe_n = 0;
    hard_reset_n = 0;
    cyc(8);
    hard_reset_n_oe_n = 1;
    hard_reset_n = 1;
    `CHK("off", 1'b0, int_supply_en)
    wt(0, 1'b1);
    wt(1, 1'b0);
    exp_on = 1;
    cmp();
  endtask
  initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    {poweroff_command, function_reset_command, temperature_supervisor_command} = 3'h0;
    {temp_sup_en, temp_out_of_range, nrst, hard_reset_n} = 4'h1;
    {power_key_n, hard_reset_n_oe_n, main_supply_ok} = 3'h7;
    void'($urandom(32'h05a26181));
    cyc(3);
    nrst = 1;
    cyc(4);
    cmp();
    poweroff_command = 1;
    cyc(1);
    poweroff_command = 0;
    `CHK("ok", 1'b0, cmd_ok)
    turn_on();
    // orderly switch-off, main supply held until the output drops
    poweroff_command = 1;
    cyc(1);
    poweroff_command = 0;
    `CHK("ok", 1'b1, cmd_ok)
    `CHK("save", 1'b1, save_req)
    wt(4, 1'b1);
    wt(0, 1'b0);
    `CHK("pins", 1'b1, pins_oe_n)
    exp_on = 0;
    cmp();
    turn_on();
    function_reset_command = 1;
    cyc(1);
    function_reset_command = 0;
    `CHK("ok", 1'b1, cmd_ok)
    `CHK("save", 1'b1, save_req)
    wt(4, 1'b1);
    wt(2, 1'b0);
    wt(2, 1'b1);
    wt(1, 1'b0);
    cmp();
    turn_on();
    main_supply_ok = 0;
    cyc(1);
    `CHK("save", 1'b0, save_req)
    exp_on = 0;
    cmp();
    main_supply_ok = 1;
    turn_on();
    // temperature ignored until the supervisor is enabled
    temp_out_of_range = 1;
    cyc(10);
    cmp();
    temperature_supervisor_command = 1;
    temp_sup_en = 1;
    cyc(1);
    temperature_supervisor_command = 0;
    wt(0, 1'b0);
    temp_out_of_range = 0;
    exp_on = 0;
    // short key pulse ignored, long ones switch on and off
    power_key_n = 0;
    cyc(50 + $urandom % 500);
    power_key_n = 1;
    cyc(20);
    cmp();
    power_key_n = 0;
    cyc(int'(KEY_MIN_CYC) + 10);
    power_key_n = 1;
    wt(0, 1'b1);
    wt(1, 1'b0);
    power_key_n = 0;
    cyc(int'(KEY_MIN_CYC) + 10);
    `CHK("save", 1'b0, save_req)
    power_key_n = 1;
    wt(3, 1'b1);
    wt(0, 1'b0);
    cmp();
    // reset in mid-run while switched on returns supply, pins and baseband reset to off
    turn_on();
    nrst = 0;
    cyc(3);
    nrst = 1;
    cyc(2);
    `CHK("pins", 1'b1, pins_oe_n)
    `CHK("bbrst", 1'b0, bb_reset_n)
    exp_on = 0;
    cmp();
    print_verdict();
  end
endmodule : pps_seq_test
`default_nettype wire
